// ---- hdl/mssr_defines.svh ----
// Constants of the speed search supervisor: offsets, fields, resets, timing
// Assumes inclusion by bare name from design files only
`ifndef MSSR_DEFINES_SVH
`define MSSR_DEFINES_SVH
`define MSSR_A_CTRL 8'h00
`define MSSR_A_CURRENT 8'h04
`define MSSR_A_TIMING 8'h08
`define MSSR_A_GAIN 8'h0C
`define MSSR_A_LEVEL 8'h10
`define MSSR_A_STATUS 8'h14
`define MSSR_A_IRQ_STATUS 8'h18
`define MSSR_A_IRQ_ENABLE 8'h1C
`define MSSR_A_IRQ_CLEAR 8'h20
`define MSSR_F_METHOD 0
`define MSSR_F_DIR_EN 1
`define MSSR_F_TRIG_SEL 2
`define MSSR_F_START_EN 3
`define MSSR_F_FAULT_RST 31
`define MSSR_IRQ_DONE 0
`define MSSR_IRQ_RETRY 1
`define MSSR_IRQ_FAULT 2
`define MSSR_R_THR 8'h96
`define MSSR_MAX_THR 8'hC8
`define MSSR_R_COEF 6'h05
`define MSSR_MAX_COEF 6'h32
`define MSSR_R_DET_TIME 7'h0A
`define MSSR_MAX_DET_TIME 7'h64
`define MSSR_R_LIMIT 4'h3
`define MSSR_MAX_LIMIT 4'hA
`define MSSR_R_WAIT 9'h005
`define MSSR_MAX_WAIT 9'h12C
`define MSSR_R_GAIN 10'h050
`define MSSR_MAX_GAIN 10'h258
`define MSSR_R_COMP 7'h69
`define MSSR_MIN_COMP 7'h64
`define MSSR_MAX_COMP 7'h78
`define MSSR_R_MINLVL 7'h3C
`define MSSR_MIN_MINLVL 7'h14
`define MSSR_MAX_MINLVL 7'h64
`define MSSR_R_DIRLVL 16'h03E8
`define MSSR_MIN_DIRLVL 16'h0028
`define MSSR_MAX_DIRLVL 16'hEA60
`define MSSR_RATED_REF 16'h03E8
`define MSSR_COMP_UNIT 23'h000064
`define MSSR_WAIT_SCALE 12'h00A
`define MSSR_CLK_PERIOD_NS 10
`define MSSR_TICK_TIME_MS 10
`define MSSR_TICK_CYCLES (`MSSR_TICK_TIME_MS * 1000000 / `MSSR_CLK_PERIOD_NS)
`endif

// ---- hdl/mssr_pkg.sv ----
// Types of the speed search supervisor
// Assumes nothing of its surroundings
package mssr_pkg;
   typedef enum logic [2:0] {
      MSSR_IDLE = 3'b000,
      MSSR_DETECT = 3'b001,
      MSSR_INJECT = 3'b010,
      MSSR_ESTIMATE = 3'b011,
      MSSR_WAIT = 3'b100,
      MSSR_RUN = 3'b101,
      MSSR_FAULT = 3'b110
   } mssr_fsm_t;

   typedef struct packed {
      mssr_fsm_t fsm;
      logic [3:0] cnt;
      logic [6:0] det_cnt;
      logic [11:0] wait_cnt;
      logic dir;
      logic [15:0] speed;
      logic done;
      logic run_q;
      logic bb_q;
      logic over_q;
      logic fault;
      logic [15:0] cur_ref;
      logic [9:0] gain_out;
      logic method;
      logic dir_en;
      logic trig_sel;
      logic start_en;
      logic [7:0] thr;
      logic [5:0] coef;
      logic [6:0] det_time;
      logic [3:0] limit;
      logic [8:0] wait_t;
      logic [9:0] gain;
      logic [6:0] comp;
      logic [6:0] minlvl;
      logic [15:0] dirlvl;
      logic [2:0] irq_st;
      logic [2:0] irq_en;
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic rdy;
      logic [31:0] rdata;
   } mssr_state_t;
endpackage

// ---- hdl/mssr_tick.sv ----
// Time base: one-cycle enable pulse every DIV clock cycles
// Assumes one clock; clr_i restarts the period so intervals start aligned
`timescale 1ns/1ps
`default_nettype none
module mssr_tick #(
   parameter int unsigned DIV = 1000000
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic clr_i,
   output logic tick_o
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;

   always_comb begin
      if (clr_i || cnt_r == DIV - 1) begin
         cnt_nxt = 32'h0;
      end else begin
         cnt_nxt = cnt_r + 32'h1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_r <= 32'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tick_o = (cnt_r == DIV - 1) && !clr_i;
endmodule
`default_nettype wire

// ---- hdl/mssr_top.sv ----
// Speed search supervisor: finds a coasting motor's speed and restarts it
// Assumes an AHB-Lite master with hready tied to hreadyout_o, and
// estimator inputs synchronous to clk_i
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mssr_defines.svh"
module mssr_top #(
   parameter int unsigned TICK_CYCLES = `MSSR_TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic run_cmd_i,
   input wire logic ext_search_cmd_i,
   input wire logic baseblock_i,
   input wire logic freq_ref_dir_i,
   input wire logic [7:0] current_pct_i,
   input wire logic [7:0] no_load_pct_i,
   input wire logic [6:0] resp_current_i,
   input wire logic [15:0] dir_metric_i,
   input wire logic dir_sign_i,
   input wire logic [15:0] speed_est_i,
   input wire logic speed_valid_i,
   output logic search_active_o,
   output logic injection_o,
   output logic [15:0] current_ref_o,
   output logic [9:0] loop_gain_o,
   output logic [15:0] restart_speed_o,
   output logic restart_dir_o,
   output logic search_done_o,
   output logic mismatch_o,
   output logic search_failure_fault_o,
   output logic drive_stop_o,
   output logic irq_o
);
   import mssr_pkg::*;

   mssr_state_t s;
   mssr_state_t n;
   logic acc;
   logic fclr;
   logic over;
   logic trig;
   logic tick;
   logic tick_clr;
   logic [15:0] prod_cur;
   logic [22:0] prod_spd;
   logic [22:0] spd_div;
   logic [11:0] wait_lim;

   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction

   function automatic logic [31:0] rd_mux(input mssr_state_t r);
      logic [31:0] d;
      d = 32'h0;
      case (r.addr)
         `MSSR_A_CTRL: begin
            d[`MSSR_F_METHOD] = r.method;
            d[`MSSR_F_DIR_EN] = r.dir_en;
            d[`MSSR_F_TRIG_SEL] = r.trig_sel;
            d[`MSSR_F_START_EN] = r.start_en;
         end
         `MSSR_A_CURRENT: d = {16'h0, 2'h0, r.coef, r.thr};
         `MSSR_A_TIMING: d = {7'h0, r.wait_t, 4'h0, r.limit, 1'h0, r.det_time};
         `MSSR_A_GAIN: d = {9'h0, r.comp, 6'h0, r.gain};
         `MSSR_A_LEVEL: d = {r.dirlvl, 9'h0, r.minlvl};
         `MSSR_A_STATUS: d = {r.speed, 7'h0, r.fault, r.dir, r.cnt, r.fsm};
         `MSSR_A_IRQ_STATUS: d = {29'h0, r.irq_st};
         `MSSR_A_IRQ_ENABLE: d = {29'h0, r.irq_en};
         default: d = 32'h0;
      endcase
      return d;
   endfunction

   mssr_tick #(
      .DIV(TICK_CYCLES)
   ) u_tick (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .clr_i(tick_clr),
      .tick_o(tick)
   );

   always_comb begin
      n = s;
      n.done = 1'b0;
      fclr = 1'b0;
      acc = hsel_i && hready_i && htrans_i[1];
      prod_cur = 16'({8'h0, 2'h0, s.coef} * {8'h0, no_load_pct_i});
      prod_spd = 23'({7'h0, speed_est_i} * {16'h0, s.comp});
      spd_div = prod_spd / `MSSR_COMP_UNIT;
      wait_lim = 12'({3'h0, s.wait_t} * `MSSR_WAIT_SCALE);
      over = (s.fsm == MSSR_INJECT || s.fsm == MSSR_ESTIMATE) && (current_pct_i > s.thr);
      trig = 1'b0;
      // Register read: one wait state, data from a flop
      if (s.rd && !s.rdy) begin
         n.rdata = rd_mux(s);
         n.rdy = 1'b1;
      end else if (s.rdy) begin
         n.rd = 1'b0;
         n.rdy = 1'b0;
      end
      // Register write in data phase
      if (s.wr) begin
         case (s.addr)
            `MSSR_A_CTRL: begin
               n.method = hwdata_i[`MSSR_F_METHOD];
               n.dir_en = hwdata_i[`MSSR_F_DIR_EN];
               n.trig_sel = hwdata_i[`MSSR_F_TRIG_SEL];
               n.start_en = hwdata_i[`MSSR_F_START_EN];
               fclr = hwdata_i[`MSSR_F_FAULT_RST];
            end
            `MSSR_A_CURRENT: begin
               n.thr = 8'(clamp16({8'h0, hwdata_i[7:0]}, 16'h0, {8'h0, `MSSR_MAX_THR}));
               n.coef = 6'(clamp16({10'h0, hwdata_i[13:8]}, 16'h0, {10'h0, `MSSR_MAX_COEF}));
            end
            `MSSR_A_TIMING: begin
               n.det_time = 7'(clamp16({9'h0, hwdata_i[6:0]}, 16'h0,
                                       {9'h0, `MSSR_MAX_DET_TIME}));
               n.limit = 4'(clamp16({12'h0, hwdata_i[11:8]}, 16'h0, {12'h0, `MSSR_MAX_LIMIT}));
               n.wait_t = 9'(clamp16({7'h0, hwdata_i[24:16]}, 16'h0, {7'h0, `MSSR_MAX_WAIT}));
            end
            `MSSR_A_GAIN: begin
               n.gain = 10'(clamp16({6'h0, hwdata_i[9:0]}, 16'h0, {6'h0, `MSSR_MAX_GAIN}));
               n.comp = 7'(clamp16({9'h0, hwdata_i[22:16]}, {9'h0, `MSSR_MIN_COMP},
                                   {9'h0, `MSSR_MAX_COMP}));
            end
            `MSSR_A_LEVEL: begin
               n.minlvl = 7'(clamp16({9'h0, hwdata_i[6:0]}, {9'h0, `MSSR_MIN_MINLVL},
                                     {9'h0, `MSSR_MAX_MINLVL}));
               n.dirlvl = clamp16(hwdata_i[31:16], `MSSR_MIN_DIRLVL, `MSSR_MAX_DIRLVL);
            end
            `MSSR_A_IRQ_ENABLE: n.irq_en = hwdata_i[2:0];
            `MSSR_A_IRQ_CLEAR: n.irq_st = s.irq_st & ~hwdata_i[2:0];
            default: n.irq_en = s.irq_en;
         endcase
      end
      n.wr = acc && hwrite_i;
      if (acc) begin
         n.addr = haddr_i;
         n.rd = !hwrite_i;
         n.rdy = 1'b0;
      end
      // Launch condition
      n.run_q = run_cmd_i;
      n.bb_q = baseblock_i;
      n.over_q = over;
      if (s.trig_sel) begin
         trig = (s.start_en || ext_search_cmd_i) && s.bb_q && !baseblock_i && run_cmd_i;
      end else begin
         trig = (s.start_en || ext_search_cmd_i) && run_cmd_i && !s.run_q;
      end
      // Search sequence
      case (s.fsm)
         MSSR_IDLE: begin
            if (trig) begin
               n.cnt = 4'h0;
               n.dir = freq_ref_dir_i;
               n.fsm = s.method ? MSSR_INJECT : MSSR_DETECT;
            end
         end
         MSSR_DETECT, MSSR_ESTIMATE: begin
            if (!run_cmd_i) begin
               n.fsm = MSSR_IDLE;
            end else if (speed_valid_i && !over) begin
               n.fsm = MSSR_RUN;
               n.cnt = 4'h0;
               n.speed = (spd_div > 23'h00FFFF) ? 16'hFFFF : spd_div[15:0];
               n.done = 1'b1;
               n.irq_st[`MSSR_IRQ_DONE] = 1'b1;
            end else if (s.fsm == MSSR_ESTIMATE && resp_current_i < s.minlvl) begin
               n.fsm = MSSR_INJECT;
            end
         end
         MSSR_INJECT: begin
            if (!run_cmd_i) begin
               n.fsm = MSSR_IDLE;
            end else if (resp_current_i >= s.minlvl && dir_metric_i >= s.dirlvl) begin
               n.dir = s.dir_en ? dir_sign_i : freq_ref_dir_i;
               n.fsm = MSSR_ESTIMATE;
            end
         end
         MSSR_WAIT: begin
            if (!run_cmd_i) begin
               n.fsm = MSSR_IDLE;
            end else if (s.wait_cnt >= wait_lim) begin
               n.fsm = s.method ? MSSR_INJECT : MSSR_DETECT;
            end else if (tick) begin
               n.wait_cnt = s.wait_cnt + 12'h1;
            end
         end
         MSSR_RUN: begin
            if (!run_cmd_i) begin
               n.fsm = MSSR_IDLE;
            end
         end
         MSSR_FAULT: begin
            if (fclr) begin
               n.fsm = MSSR_IDLE;
               n.fault = 1'b0;
            end
         end
         default: n.fsm = MSSR_IDLE;
      endcase
      // Overcurrent watch during injection and estimation
      if (over && n.fsm != MSSR_IDLE) begin
         if (s.det_cnt >= s.det_time) begin
            n.det_cnt = 7'h0;
            n.wait_cnt = 12'h0;
            if (s.cnt >= s.limit) begin
               n.fsm = MSSR_FAULT;
               n.fault = 1'b1;
               n.irq_st[`MSSR_IRQ_FAULT] = 1'b1;
            end else begin
               n.cnt = s.cnt + 4'h1;
               n.fsm = MSSR_WAIT;
               n.irq_st[`MSSR_IRQ_RETRY] = 1'b1;
            end
         end else if (tick && s.over_q) begin
            n.det_cnt = s.det_cnt + 7'h1;
         end
      end else begin
         n.det_cnt = 7'h0;
      end
      tick_clr = (n.fsm == MSSR_WAIT && s.fsm != MSSR_WAIT) || (over && !s.over_q);
      if (n.fsm == MSSR_INJECT || n.fsm == MSSR_ESTIMATE) begin
         n.cur_ref = (prod_cur > `MSSR_RATED_REF) ? `MSSR_RATED_REF : prod_cur;
         n.gain_out = s.gain;
      end else begin
         n.cur_ref = 16'h0;
         n.gain_out = 10'h0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
         s.fsm <= MSSR_IDLE;
         s.dir_en <= 1'b1;
         s.thr <= `MSSR_R_THR;
         s.coef <= `MSSR_R_COEF;
         s.det_time <= `MSSR_R_DET_TIME;
         s.limit <= `MSSR_R_LIMIT;
         s.wait_t <= `MSSR_R_WAIT;
         s.gain <= `MSSR_R_GAIN;
         s.comp <= `MSSR_R_COMP;
         s.minlvl <= `MSSR_R_MINLVL;
         s.dirlvl <= `MSSR_R_DIRLVL;
      end else begin
         s <= n;
      end
   end

   assign hreadyout_o = !(s.rd && !s.rdy);
   assign hresp_o = 1'b0;
   assign hrdata_o = s.rdata;
   assign search_active_o = (s.fsm == MSSR_DETECT) || (s.fsm == MSSR_INJECT) ||
                            (s.fsm == MSSR_ESTIMATE) || (s.fsm == MSSR_WAIT);
   assign injection_o = (s.fsm == MSSR_INJECT);
   assign current_ref_o = s.cur_ref;
   assign loop_gain_o = s.gain_out;
   assign restart_speed_o = s.speed;
   assign restart_dir_o = s.dir;
   assign search_done_o = s.done;
   assign mismatch_o = s.over_q;
   assign search_failure_fault_o = s.fault;
   assign drive_stop_o = s.fault;
   assign irq_o = |(s.irq_st & s.irq_en);
endmodule
`default_nettype wire

// ---- testbench/mssr_motor_model.sv ----
// Coasting motor seen through the output stage
// Assumes the drive clock; over_i and dly_i are set by the bench
`timescale 1ns/1ps
`default_nettype none
module mssr_motor_model (
   input wire logic clk_i,
   input wire logic search_active_i,
   input wire logic [15:0] current_ref_i,
   input wire logic over_i,
   input wire logic [7:0] dly_i,
   input wire logic [15:0] speed_i,
   input wire logic dir_i,
   output logic [7:0] current_pct_o,
   output logic [6:0] resp_current_o,
   output logic [15:0] dir_metric_o,
   output logic dir_sign_o,
   output logic [15:0] speed_est_o,
   output logic speed_valid_o
);
   int n = 0;
   logic drv;
   always @(posedge clk_i) n <= search_active_i ? n + 1 : 0;
   always_comb begin
      drv = current_ref_i != 16'h0000;
      current_pct_o = drv ? (over_i ? 8'hBE : 8'h28) : 8'h00;
      resp_current_o = drv ? 7'h50 : 7'h00;
      dir_metric_o = drv ? 16'h07D0 : 16'h0000;
      dir_sign_o = dir_i;
      // Speed is only found after a slow or quick settling time
      speed_valid_o = !over_i && n > int'(dly_i);
      speed_est_o = speed_valid_o ? speed_i : ~speed_i;
   end
endmodule
`default_nettype wire

// ---- testbench/mssr_top_asserts.sv ----
// Port checks of the speed search supervisor
// Assumes binding onto mssr_top
`timescale 1ns/1ps
`default_nettype none
module mssr_top_asserts (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic search_active_o,
   input wire logic injection_o,
   input wire logic [15:0] current_ref_o,
   input wire logic [9:0] loop_gain_o,
   input wire logic search_done_o,
   input wire logic mismatch_o,
   input wire logic search_failure_fault_o,
   input wire logic drive_stop_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_rd_wait;
      hsel_i && hready_i && htrans_i[1] && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_stop;
      drive_stop_o == search_failure_fault_o &&
         (!drive_stop_o || (!search_active_o && current_ref_o == 16'h0000));
   endproperty
   a_stop: assert property (p_stop) else $error("stop differs from fault");
   property p_clamp;
      current_ref_o <= 16'h03E8;
   endproperty
   a_clamp: assert property (p_clamp) else $error("current above rated");
   property p_idle_out;
      !search_active_o |-> current_ref_o == 16'h0000 && loop_gain_o == 10'h000;
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("drive outside search");
   property p_inj;
      injection_o |-> search_active_o;
   endproperty
   a_inj: assert property (p_inj) else $error("injection while idle");
   property p_done;
      search_done_o |=> !search_done_o && !search_active_o && !search_failure_fault_o;
   endproperty
   a_done: assert property (p_done) else $error("done pulse wrong");
   property p_fault;
      $rose(search_failure_fault_o) |-> $past(search_active_o);
   endproperty
   a_fault: assert property (p_fault) else $error("fault outside search");
   property p_mis;
      mismatch_o |-> $past(search_active_o);
   endproperty
   a_mis: assert property (p_mis) else $error("mismatch outside search");
   c_done: cover property (search_done_o);
   c_fault: cover property ($rose(search_failure_fault_o));
   c_mis: cover property (mismatch_o);
endmodule
bind mssr_top mssr_top_asserts u_chk (.*);
`default_nettype wire

// ---- testbench/mssr_tb_top.sv ----
// Bench of the speed search supervisor: bus, search, retry, fault
// Assumes the motor model and the checker bind are compiled first
`timescale 1ns/1ps
`default_nettype none
module mssr_tb_top;
   localparam int TK = 4;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] haddr_i = 8'h00;
   logic [1:0] htrans_i = 2'b00;
   logic hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0;
   logic run_cmd_i = 1'b0;
   logic ext_search_cmd_i = 1'b0;
   logic baseblock_i = 1'b0;
   logic freq_ref_dir_i = 1'b0;
   logic [7:0] no_load_pct_i = 8'h28;
   logic over = 1'b0;
   logic mdir = 1'b0;
   logic inj_q = 1'b0;
   logic [7:0] dly = 8'h0C;
   logic [15:0] spd = 16'h1234;
   logic hreadyout_o, hresp_o, restart_dir_o, search_done_o, mismatch_o, irq_o;
   logic search_active_o, injection_o, search_failure_fault_o, drive_stop_o;
   logic dir_sign_i, speed_valid_i;
   logic [31:0] hrdata_o;
   logic [7:0] current_pct_i;
   logic [6:0] resp_current_i;
   logic [15:0] dir_metric_i, speed_est_i, current_ref_o, restart_speed_o, cref_c;
   logic [9:0] loop_gain_o, lg_c;
   int fail_count = 0;
   int checked = 0;
   int inj_n = 0, hc = 0, hl = 0, gc = 0, gl = 0;
   mssr_top #(.TICK_CYCLES(TK)) DUT (
      .clk_i, .resetn_i, .hsel_i(1'b1), .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
      .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o, .run_cmd_i,
      .ext_search_cmd_i, .baseblock_i, .freq_ref_dir_i, .current_pct_i, .no_load_pct_i,
      .resp_current_i, .dir_metric_i, .dir_sign_i, .speed_est_i, .speed_valid_i,
      .search_active_o, .injection_o, .current_ref_o, .loop_gain_o, .restart_speed_o,
      .restart_dir_o, .search_done_o, .mismatch_o, .search_failure_fault_o,
      .drive_stop_o, .irq_o);
   mssr_motor_model u_mot (.clk_i(clk_i), .search_active_i(search_active_o),
      .current_ref_i(current_ref_o), .over_i(over), .dly_i(dly), .speed_i(spd),
      .dir_i(mdir), .current_pct_o(current_pct_i), .resp_current_o(resp_current_i),
      .dir_metric_o(dir_metric_i), .dir_sign_o(dir_sign_i), .speed_est_o(speed_est_i),
      .speed_valid_o(speed_valid_i));
   initial forever #5 clk_i = ~clk_i;
   // Injection count, drive levels, lengths of drive and wait stretches
   always @(posedge clk_i) begin
      inj_q <= injection_o;
      if (injection_o && !inj_q) inj_n <= inj_n + 1;
      if (injection_o) begin
         cref_c <= current_ref_o;
         lg_c <= loop_gain_o;
      end
      hc <= (current_ref_o != 16'h0000) ? hc + 1 : 0;
      if (current_ref_o == 16'h0000 && hc != 0) hl <= hc;
      gc <= (search_active_o && current_ref_o == 16'h0000) ? gc + 1 : 0;
      if (current_ref_o != 16'h0000 && gc != 0) gl <= gc;
   end
   function automatic logic [15:0] exp_spd(input logic [15:0] s, input logic [6:0] c);
      logic [23:0] p;
      p = 24'(s) * 24'(c) / 24'h000064;
      return (p > 24'h00FFFF) ? 16'hFFFF : p[15:0];
   endfunction
   function automatic logic [15:0] exp_cur(input logic [5:0] c, input logic [7:0] n);
      logic [15:0] p;
      p = 16'(c) * 16'(n);
      return (p > 16'h03E8) ? 16'h03E8 : p;
   endfunction
   function automatic logic sig(input int k);
      case (k)
         0: return hreadyout_o;
         1: return search_done_o;
         2: return search_failure_fault_o;
         default: return search_active_o;
      endcase
   endfunction
   task automatic tally_and_finish;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int k, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
         if (n > lim) begin
            fail_count++;
            $display("[ERR] %0t wait %0d timed out", $time, k);
            tally_and_finish();
         end
      end while (sig(k) !== 1'b1);
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      htrans_i <= 2'b10;
      hwrite_i <= w;
      haddr_i <= a;
      wt(0, 20);
      htrans_i <= 2'b00;
      hwdata_i <= d;
      wt(0, 20);
      q = hrdata_o;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk(q, e);
      chk(hresp_o, 32'h0);
   endtask
   initial begin
      logic [31:0] r;
      logic [6:0] cmp;
      logic [5:0] cf;
      logic [9:0] g;
      int i0;
      void'($urandom(15));
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      rdc(8'h00, 32'h00000002);
      rdc(8'h04, 32'h00000596);
      rdc(8'h08, 32'h0005030A);
      rdc(8'h0C, 32'h00690050);
      rdc(8'h10, 32'h03E8003C);
      wr(8'h24, 32'hFFFFFFFF);
      rdc(8'h24, 32'h00000000);
      wr(8'h04, 32'hFFFFFFFF);
      rdc(8'h04, 32'h000032C8);
      wr(8'h10, 32'h00000000);
      rdc(8'h10, 32'h00280014);
      for (int i = 0; i < 4; i++) begin
         cmp = 7'(7'h64 + $urandom_range(20));
         cf = 6'(1 + $urandom_range(49));
         g = 10'($urandom_range(600));
         spd <= (i == 0) ? 16'hFFFF : 16'($urandom);
         no_load_pct_i <= 8'(1 + $urandom_range(254));
         mdir <= 1'($urandom);
         freq_ref_dir_i <= 1'($urandom);
         dly <= 8'($urandom_range(20));
         wr(8'h0C, {9'h0, cmp, 6'h0, g});
         rdc(8'h0C, {9'h0, cmp, 6'h0, g});
         wr(8'h04, {18'h0, cf, 8'h96});
         wr(8'h00, {28'h0, 1'b1, 1'b0, i[1], i[0]});
         i0 = inj_n;
         run_cmd_i <= 1'b1;
         wt(1, 400);
         chk(restart_speed_o, exp_spd(spd, cmp));
         chk(32'(inj_n - i0), 32'(i[0]));
         if (i[0]) begin
            chk(restart_dir_o, i[1] ? mdir : freq_ref_dir_i);
            chk(cref_c, exp_cur(cf, no_load_pct_i));
            chk(lg_c, g);
         end
         run_cmd_i <= 1'b0;
         @(posedge clk_i);
      end
      // Direction level, then minimum current level, kept out of reach: injection must hold
      for (int k = 0; k < 2; k++) begin
         wr(8'h10, (k == 0) ? 32'h08000014 : 32'h00280051);
         run_cmd_i <= 1'b1;
         repeat (10) @(posedge clk_i);
         chk(injection_o, (k == 0) ? 1'b1 : 1'b1);
         run_cmd_i <= 1'b0;
         @(posedge clk_i);
      end
      wr(8'h10, 32'h00280014);
      wr(8'h00, 32'h00000006);
      ext_search_cmd_i <= 1'b1;
      baseblock_i <= 1'b1;
      run_cmd_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(search_active_o, 1'b0);
      baseblock_i <= 1'b0;
      wt(3, 10);
      run_cmd_i <= 1'b0;
      ext_search_cmd_i <= 1'b0;
      wr(8'h08, 32'h00010102);
      wr(8'h00, 32'h0000000B);
      wr(8'h20, 32'h00000007);
      wr(8'h1C, 32'h00000004);
      over <= 1'b1;
      i0 = inj_n;
      run_cmd_i <= 1'b1;
      wt(2, 2000);
      repeat (2) @(posedge clk_i);
      chk(32'(inj_n - i0), 32'h2);
      chk(drive_stop_o, 1'b1);
      chk(hl >= 2 * TK && hl <= 2 * TK + 4, 1'b1);
      chk(gl >= 9 * TK && gl <= 11 * TK, 1'b1);
      rdc(8'h18, 32'h00000006);
      chk(irq_o, 1'b1);
      wr(8'h1C, 32'h00000000);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      wr(8'h1C, 32'h00000004);
      wr(8'h20, 32'h00000004);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      run_cmd_i <= 1'b0;
      wr(8'h00, 32'h8000000B);
      repeat (2) @(posedge clk_i);
      chk(search_failure_fault_o, 1'b0);
      run_cmd_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk(mismatch_o, 1'b1);
      repeat (15) @(posedge clk_i);
      over <= 1'b0;
      wt(1, 400);
      ahb(1'b0, 8'h14, 32'h0, r);
      chk(r[6:3], 4'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
